//--- rtl/nand_host_ctrl.sv
// Host controller driving an asynchronous flash bus
`timescale 1ns/1ps
module nand_host_ctrl
    import nand_host_pkg::*;
#(
    parameter int WIDE      = 0,
    parameter int POWER_CYC = POWER_WAIT_CYC,
    parameter int RESET_CYC = RESET_BUSY_CYC,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // Request port
    input  wire logic [1:0]  reqOp,
    input  wire logic [15:0] reqData,
    input  wire logic        reqValid,
    output logic             reqReady,
    input  wire logic        guardReq,
    input  wire logic        useReadyBusy,
    // Read data out
    output logic [15:0]      rdData,
    output logic             rdValid,
    input  wire logic        rdReady,
    // Status
    output logic             initDone,
    output logic             targetBusy,
    // Flash pins
    output logic             chipEnableN,
    output logic             cmdLatchEnable,
    output logic             addrLatchEnable,
    output logic             writeStrobeN,
    output logic             readStrobeN,
    output logic             programEraseGuardN,
    output logic [15:0]      ioOut,
    output logic [15:0]      ioOe,
    input  wire logic [15:0] ioIn,
    input  wire logic        readyBusyN
);
    initial begin
        if (WIDE > 1 || POWER_CYC < 1 || RESET_CYC < 1) begin
            $error("Bad controller parameter");
        end
    end
    localparam int CW = $clog2(POWER_CYC + RESET_CYC + 2);

    // Three-stage pin synchroniser; second and third must agree
    logic [2:0] rbSync_q;
    logic       rbStable_q, rbStable_d;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rbSync_q   <= 3'h0;
            rbStable_q <= 1'b0;
        end else begin
            rbSync_q   <= {rbSync_q[1:0], readyBusyN};
            rbStable_q <= rbStable_d;
        end
    end
    always_comb begin
        rbStable_d = rbStable_q;
        if (rbSync_q[1] == rbSync_q[2]) begin
            rbStable_d = rbSync_q[2];
        end
    end
    assign targetBusy = !rbStable_q;

    // Read-data FIFO; a full FIFO stalls further read cycles
    logic        fInValid, fInReady;
    logic [15:0] fInData;
    nand_host_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .inData   (fInData),
        .inValid  (fInValid),
        .inReady  (fInReady),
        .outData  (rdData),
        .outValid (rdValid),
        .outReady (rdReady)
    );

    state_type   state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    op_type      op_q, op_d;
    logic [15:0] out_q, out_d;
    logic [15:0] oe_q, oe_d;
    logic        ce_q, ce_d, cle_q, cle_d, ale_q, ale_d;
    logic        we_q, we_d, re_q, re_d, guard_q, guard_d;
    logic        done_q, done_d;
    logic [15:0] cap_q, cap_d;
    logic        push_q, push_d;
    logic [15:0] dataMask;

    assign dataMask = (WIDE != 0) ? 16'hffff : 16'h00ff;
    assign fInData  = cap_q;
    assign fInValid = push_q;
    // A pending guard change goes first, so ready never promises a take
    assign reqReady = (state_q == ST_IDLE) && rbStable_q && fInReady
                      && !push_q && (guardReq == guard_q);

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        op_d    = op_q;
        out_d   = out_q;
        oe_d    = oe_q;
        ce_d    = ce_q;
        cle_d   = cle_q;
        ale_d   = ale_q;
        we_d    = we_q;
        re_d    = re_q;
        guard_d = guard_q;
        done_d  = done_q;
        cap_d   = cap_q;
        push_d  = 1'b0;
        unique case (state_q)
            ST_POWER: begin
                // Guard held low until supply settles
                // Count saturates so a slow ready/busy cannot wrap it
                if (cnt_q < CW'(POWER_CYC)) begin
                    cnt_d = cnt_q + 1'b1;
                end
                if (cnt_q >= CW'(POWER_CYC)
                    && (!useReadyBusy || rbStable_q)) begin
                    cnt_d   = '0;
                    op_d    = OP_CMD;
                    out_d   = {8'h00, CMD_RESET};
                    state_d = ST_RSTCMD;
                end
            end
            ST_RSTCMD: begin
                ce_d    = 1'b0;
                cle_d   = 1'b1;
                ale_d   = 1'b0;
                oe_d    = dataMask;
                we_d    = 1'b0;
                cnt_d   = '0;
                state_d = ST_LOW;
            end
            ST_RSTWT: begin
                // Target stays busy after reset; wait fixed time
                if (cnt_q < CW'(RESET_CYC)) begin
                    cnt_d = cnt_q + 1'b1;
                end
                if (cnt_q >= CW'(RESET_CYC)
                    && (!useReadyBusy || rbStable_q)) begin
                    done_d  = 1'b1;
                    cnt_d   = '0;
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                ce_d  = 1'b1;
                oe_d  = 16'h0000;
                cle_d = 1'b0;
                ale_d = 1'b0;
                if (guardReq != guard_q && rbStable_q) begin
                    guard_d = guardReq;
                    cnt_d   = '0;
                    state_d = ST_GUARD;
                end else if (reqValid && reqReady) begin
                    op_d  = op_type'(reqOp);
                    ce_d  = 1'b0;
                    cle_d = op_type'(reqOp) == OP_CMD;
                    ale_d = op_type'(reqOp) == OP_ADDR;
                    // Commands and addresses on the low byte only
                    if (op_type'(reqOp) inside {OP_CMD, OP_ADDR}) begin
                        out_d = {8'h00, reqData[7:0]};
                    end else begin
                        out_d = reqData & dataMask;
                    end
                    oe_d = (op_type'(reqOp) == OP_DRD) ? 16'h0000
                                                       : dataMask;
                    if (op_type'(reqOp) == OP_DRD) begin
                        re_d = 1'b0;
                    end else begin
                        we_d = 1'b0;
                    end
                    cnt_d   = '0;
                    state_d = ST_LOW;
                end
            end
            ST_LOW: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q + 1'b1 >= CW'(STROBE_LOW_CYC)) begin
                    we_d    = 1'b1;
                    re_d    = 1'b1;
                    cnt_d   = '0;
                    state_d = ST_HIGH;
                    // Sample on the rising read strobe edge
                    if (op_q == OP_DRD) begin
                        cap_d  = ioIn & dataMask;
                        push_d = 1'b1;
                    end
                end
            end
            ST_HIGH: begin
                // Hold data past the strobe rise before release
                cnt_d = cnt_q + 1'b1;
                if (cnt_q + 1'b1 >= CW'(STROBE_HI_CYC)) begin
                    cnt_d   = '0;
                    // After a command the pin needs time to show busy
                    if (!done_q) begin
                        state_d = ST_RSTWT;
                    end else if (op_q == OP_CMD) begin
                        state_d = ST_GUARD;
                    end else begin
                        state_d = ST_IDLE;
                    end
                    oe_d    = 16'h0000;
                    cle_d   = 1'b0;
                    ale_d   = 1'b0;
                    ce_d    = 1'b1;
                end
            end
            ST_GUARD: begin
                // Guard settle; also covers the busy sync after a command
                cnt_d = cnt_q + 1'b1;
                if (cnt_q + 1'b1 >= CW'(GUARD_SETTLE_CYC)) begin
                    cnt_d   = '0;
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_POWER;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_POWER;
            cnt_q   <= '0;
            op_q    <= OP_CMD;
            out_q   <= 16'h0000;
            oe_q    <= 16'h0000;
            ce_q    <= 1'b1;
            cle_q   <= 1'b0;
            ale_q   <= 1'b0;
            we_q    <= 1'b1;
            re_q    <= 1'b1;
            guard_q <= 1'b0;
            done_q  <= 1'b0;
            cap_q   <= 16'h0000;
            push_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            op_q    <= op_d;
            out_q   <= out_d;
            oe_q    <= oe_d;
            ce_q    <= ce_d;
            cle_q   <= cle_d;
            ale_q   <= ale_d;
            we_q    <= we_d;
            re_q    <= re_d;
            guard_q <= guard_d;
            done_q  <= done_d;
            cap_q   <= cap_d;
            push_q  <= push_d;
        end
    end

    assign chipEnableN        = ce_q;
    assign cmdLatchEnable     = cle_q;
    assign addrLatchEnable    = ale_q;
    assign writeStrobeN       = we_q;
    assign readStrobeN        = re_q;
    assign programEraseGuardN = guard_q;
    assign ioOut              = out_q;
    assign ioOe               = oe_q;
    assign initDone           = done_q;

    sequence s_weRise;
        $rose(writeStrobeN);
    endsequence
    sequence s_holdOff;
        !reqReady [*4];
    endsequence
    a_latch_exclusive: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        s_weRise |-> !(cmdLatchEnable && addrLatchEnable))
        else $error("Both latch enables high at strobe rise");
    a_cmd_upper_zero: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        s_weRise and cmdLatchEnable |-> ioOut[15:8] == 8'h00)
        else $error("Upper byte not zero in command cycle");
    a_strobe_ce_low: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        s_weRise |-> !chipEnableN && readStrobeN)
        else $error("Strobe rise without chip enable");
    a_first_reset: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        s_weRise and !initDone |-> cmdLatchEnable
            && ioOut[7:0] == CMD_RESET)
        else $error("First command not reset");
    a_guard_idle: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        $changed(programEraseGuardN) |-> chipEnableN && initDone)
        else $error("Guard changed during sequence");
    a_power_guard: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !initDone |-> !programEraseGuardN)
        else $error("Guard released before init");
    a_read_no_drive: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !readStrobeN |-> ioOe == 16'h0000)
        else $error("Host drives bus during read");
    a_addr_low_byte: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        s_weRise and addrLatchEnable |-> ioOut[15:8] == 8'h00)
        else $error("Upper byte set in address cycle");
    a_cmd_busy_wait: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        s_weRise and cmdLatchEnable and initDone |-> s_holdOff)
        else $error("Request taken before busy could show");
    a_guard_settle: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        $changed(programEraseGuardN) |-> s_holdOff)
        else $error("Request taken during guard settle");
endmodule

//--- rtl/nand_host_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module nand_host_fifo
    import nand_host_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    // Fill side
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    // Drain side
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("FIFO depth must be a power of two, width positive");
        end
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW:0]      wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic             push, pop;

    assign inReady  = (wrPtr_q - rdPtr_q) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_q != rdPtr_q;
    assign outData  = mem_q[rdPtr_q[AW-1:0]];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        mem_d   = mem_q;
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        if (push) begin
            mem_d[wrPtr_q[AW-1:0]] = inData;
            wrPtr_d = wrPtr_q + 1'b1;
        end
        if (pop) begin
            rdPtr_d = rdPtr_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            mem_q   <= mem_d;
        end
    end
endmodule

//--- rtl/nand_host_pkg.sv
// Constants shared by the asynchronous flash bus host controller
// Summary of operation
// - Command byte latched on strobe rise, CLE high
// - Address byte latched on strobe rise, ALE high
// - Data latched on strobe rise, both latches low
// - Host zeroes upper byte during command cycles
// - Host zeroes unused address bits, correct count
// - Sample on rise when cycle at least 30ns
// - Issue read mode after enhanced status read
// - Guard changes only when idle, then settle
// - Hold guard low during power-on
// - Wait for ready/busy valid, high, before reset
// - Unmonitored host waits 100us after supply
// - Reset first; target busy for 1ms
// - Five address cycles: column, page, block
package nand_host_pkg;
    localparam int CLK_MHZ        = 50;
    localparam int CYC_NS         = 1000 / CLK_MHZ;
    localparam int READ_CYCLE_NS  = 30;
    localparam int STROBE_LOW_CYC = ((READ_CYCLE_NS / 2) + CYC_NS - 1) / CYC_NS;
    localparam int STROBE_HI_CYC  = ((READ_CYCLE_NS / 2) + CYC_NS - 1) / CYC_NS;
    localparam int POWER_WAIT_US  = 100;
    localparam int POWER_WAIT_CYC = POWER_WAIT_US * CLK_MHZ;
    localparam int RESET_BUSY_US  = 1000;
    localparam int RESET_BUSY_CYC = RESET_BUSY_US * CLK_MHZ;
    localparam int GUARD_SETTLE_NS = 100;
    localparam int GUARD_SETTLE_CYC =
        (GUARD_SETTLE_NS + CYC_NS - 1) / CYC_NS;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam int ADDR_CYCLES    = 5;
    typedef enum logic [1:0] {
        OP_CMD  = 2'h0,
        OP_ADDR = 2'h1,
        OP_DWR  = 2'h2,
        OP_DRD  = 2'h3
    } op_type;
    typedef enum logic [2:0] {
        ST_POWER  = 3'h0,
        ST_RSTCMD = 3'h1,
        ST_RSTWT  = 3'h3,
        ST_IDLE   = 3'h2,
        ST_LOW    = 3'h6,
        ST_HIGH   = 3'h7,
        ST_GUARD  = 3'h5
    } state_type;
endpackage

//--- sim/nand_async_bus_interface_test.sv
// Self-checking bench for the flash bus host controller
`timescale 1ns/1ps
module nand_async_bus_interface_test;
    import nand_host_pkg::*;
    logic        sys_clk, rstn, reqValid, reqReady, guardReq, rdValid;
    logic        rdReady, initDone, targetBusy, ceN, cle, ale, weN, reN;
    logic        guardN, devOe, rbLow, useRb;
    logic [1:0]  reqOp;
    logic [15:0] reqData, rdData, ioOut, ioOe, ioBus, devOut, flt;
    int          errorCnt, checks;
    // Released lines wander so a stale value never looks valid
    always @(posedge sys_clk) flt <= flt + 16'h1357;
    assign ioBus = ioOe[0] ? ioOut : devOe ? devOut : flt;
    nand_host_ctrl #(.WIDE(1), .POWER_CYC(20), .RESET_CYC(40)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .reqOp(reqOp), .reqData(reqData),
        .reqValid(reqValid), .reqReady(reqReady), .guardReq(guardReq),
        .useReadyBusy(useRb), .rdData(rdData), .rdValid(rdValid),
        .rdReady(rdReady), .initDone(initDone), .targetBusy(targetBusy),
        .chipEnableN(ceN), .cmdLatchEnable(cle), .addrLatchEnable(ale),
        .writeStrobeN(weN), .readStrobeN(reN),
        .programEraseGuardN(guardN), .ioOut(ioOut), .ioOe(ioOe),
        .ioIn(ioBus), .readyBusyN(!rbLow));
    nand_dev_model dev (
        .ceN(ceN), .cle(cle), .ale(ale), .weN(weN), .reN(reN),
        .guardN(guardN), .bus(ioBus), .devOut(devOut), .devOe(devOe),
        .rbLow(rbLow));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errorCnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask
    task automatic req(input logic [1:0] op, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge sys_clk);
        reqOp = op;
        reqData = d;
        reqValid = 1'b1;
        while (reqReady !== 1'b1 && n < 500) begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        reqValid = 1'b0;
        chk(16'(n < 500), 16'h0001);
    endtask
    task automatic pop(input logic [15:0] exp);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (rdValid !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        chk(rdData, exp);
        rdReady = 1'b1;
        @(negedge sys_clk);
        rdReady = 1'b0;
    endtask
    task automatic program_page(input logic [15:0] a, input logic [15:0] b);
        req(OP_CMD, 16'h0080);
        req(OP_ADDR, 16'h0000);
        req(OP_ADDR, 16'h0000);
        req(OP_ADDR, 16'h0041);
        req(OP_ADDR, 16'h0002);
        req(OP_ADDR, 16'h0001);
        req(OP_DWR, a);
        req(OP_DWR, b);
        req(OP_CMD, 16'h0010);
        repeat (12) @(negedge sys_clk);
    endtask
    task automatic t_init();
        int n;
        n = 0;
        while (initDone !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        chk(16'(dev.firstCmd), 16'h00ff);
        chk(16'(dev.early), 16'h0000);
        chk(16'(dev.busy), 16'h0000);
        chk(16'(guardN), 16'h0000);
        chk(16'(ceN), 16'h0001);
        $display("init test done");
    endtask
    task automatic t_protect();
        program_page(16'h1234, 16'habcd);
        chk(16'(dev.progs), 16'h0000);
        chk(dev.cache[1], 16'habcd);
        chk(16'(dev.addr[2]), 16'h0041);
        chk(16'(dev.upper), 16'h0000);
        $display("protect test done");
    endtask
    task automatic t_program();
        guardReq = 1'b1;
        repeat (20) @(negedge sys_clk);
        chk(16'(guardN), 16'h0001);
        program_page(16'h8001, 16'h7ffe);
        chk(16'(targetBusy), 16'h0001);
        chk(16'(reqReady), 16'h0000);
        chk(16'(dev.progs), 16'h0001);
        chk(16'(dev.lastCmd), 16'h0010);
        $display("program test done");
    endtask
    task automatic t_read();
        req(OP_CMD, 16'h0000);
        for (int i = 0; i < 5; i++) req(OP_ADDR, 16'h0000);
        req(OP_CMD, 16'h0030);
        for (int i = 0; i < 16; i++) req(OP_DRD, 16'h0000);
        repeat (8) @(negedge sys_clk);
        chk(16'(reqReady), 16'h0000);
        pop(16'h8001);
        pop(16'h7ffe);
        for (int i = 2; i < 16; i++) pop(16'hc000 + 16'(i));
        repeat (3) @(negedge sys_clk);
        chk(16'(reqReady), 16'h0001);
        $display("read test done");
    endtask
    task automatic t_status();
        req(OP_CMD, 16'h0070);
        req(OP_DRD, 16'h0000);
        pop(16'h00c0);
        req(OP_CMD, 16'h0078);
        for (int i = 0; i < 3; i++) req(OP_ADDR, 16'h0000);
        req(OP_DRD, 16'h0000);
        pop(16'h00c0);
        req(OP_CMD, 16'h0000);
        repeat (4) @(negedge sys_clk);
        chk(16'(dev.mode), 16'h0000);
        $display("status test done");
    endtask
    task automatic t_reinit();
        int n;
        n = 0;
        useRb = 1'b0;
        guardReq = 1'b0;
        rstn = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk(16'(guardN), 16'h0000);
        chk(16'(initDone), 16'h0000);
        rstn = 1'b1;
        while (initDone !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        // Without the pin both fixed waits must still elapse
        chk(16'(n >= 60 && n < 2000), 16'h0001);
        chk(16'(dev.lastCmd), 16'h00ff);
        chk(16'(dev.busy), 16'h0000);
        $display("reinit test done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #100us;
        errorCnt++;
        conclude();
    end
    initial begin
        {errorCnt, checks} = '0;
        {rstn, reqValid, guardReq, rdReady} = '0;
        reqOp = 2'h0;
        reqData = 16'h0000;
        flt = 16'h0000;
        useRb = 1'b1;
        repeat (5) @(negedge sys_clk);
        rstn = 1'b1;
        t_init();
        t_protect();
        t_program();
        t_read();
        t_status();
        t_reinit();
        conclude();
    end
endmodule

//--- sim/nand_dev_model.sv
// Behavioural flash target as seen from the host's pins
`timescale 1ns/1ps
module nand_dev_model #(
    parameter int RB_NS   = 800,
    parameter int RST_NS  = 600,
    parameter int BUSY_NS = 1500
) (
    // Host pins
    input  wire logic        ceN,
    input  wire logic        cle,
    input  wire logic        ale,
    input  wire logic        weN,
    input  wire logic        reN,
    input  wire logic        guardN,
    input  wire logic [15:0] bus,
    // Device drive
    output logic [15:0]      devOut,
    output logic             devOe,
    output logic             rbLow
);
    logic [7:0]  lastCmd;
    logic [7:0]  firstCmd;
    logic [7:0]  addr [0:4];
    logic [15:0] cache [0:31];
    logic [7:0]  c;
    int          ptr, aCnt, mode, progs, early, upper;
    logic        busy, valid;
    task automatic occupy(input int ns);
        busy = 1'b1;
        fork
            #ns busy = 1'b0;
        join_none
    endtask
    initial begin
        busy = 1'b0;
        valid = 1'b0;
        devOe = 1'b0;
        devOut = 16'h0000;
        firstCmd = 8'h00;
        {ptr, aCnt, mode, progs, early, upper} = '0;
        for (int i = 0; i < 32; i++) cache[i] = 16'hc000 + 16'(i);
        // Pin is not trustworthy until the supply has settled
        #RB_NS valid = 1'b1;
    end
    always @(posedge weN) begin
        c = bus[7:0];
        if (!ceN && reN && !(cle && ale)) begin
            if (cle) begin
                if (!valid) early++;
                if (bus[15:8] != 8'h00) upper++;
                if (firstCmd == 8'h00) firstCmd = c;
                if (!busy || c inside {8'h70, 8'h78}) begin
                    lastCmd = c;
                    aCnt = 0;
                    mode = c inside {8'h70, 8'h78} ? 2 : c == 8'h30;
                    if (c inside {8'h80, 8'h30}) ptr = 0;
                    if (c == 8'hff) occupy(RST_NS);
                    if (c == 8'h30) occupy(BUSY_NS / 4);
                    if (c == 8'h10 && guardN) begin
                        progs++;
                        occupy(BUSY_NS);
                    end
                end
            end else if (ale) begin
                if ((!busy || lastCmd == 8'h78) && aCnt < 5) begin
                    addr[aCnt] = c;
                    aCnt++;
                end
            end else if (!busy) begin
                cache[ptr[4:0]] = bus;
                ptr++;
            end
        end
    end
    always @(negedge reN) begin
        // Select lines change on the same host edge; let them settle
        #1;
        if (!ceN && !cle && !ale && weN) begin
            if (mode == 2) devOut = {8'h00, guardN, !busy, 6'h00};
            else if (mode == 1 && !busy) devOut = cache[ptr[4:0]];
            devOe = mode == 2 || (mode == 1 && !busy);
            if (mode == 1 && !busy) ptr++;
        end
    end
    // Short output hold, then the lines are let go
    always @(posedge reN or posedge ceN) #5 devOe = 1'b0;
    assign rbLow = busy || !valid;
endmodule
